/* hdl/csc_clock_ctrl.sv */
// Clock source control: oscillator start/stop, clock select, CPU divider
// Functional notes
// - STOP instruction enters stop mode and halts crystal or external input
// - STOP instruction also halts the internal high-speed oscillator
// - Status flag reads 0 on internal high-speed, 1 on high-speed system
// - Writing 1 to high-speed stop halts crystal or external input unless the CPU runs on it
// - Clearing internal high-speed stop bit starts that oscillator
// - Stable flag rises once accuracy settles; software waits on it
// - After reset internal high-speed runs and feeds the CPU
// - Two select bits pick main and peripheral clock sources
// - External select picks crystal or external input for high-speed
// - Three-bit code divides CPU clock by 1..16; default 2, rest ignored
// - Writing 1 to internal high-speed stop halts that oscillator only while the CPU runs on high-speed
// - Low-speed oscillator never feeds CPU; only watchdog and one timer
// - Low-speed starts at reset and drives watchdog when enabled
// - Low-speed stop bit 1 stops it, 0 restarts it
// - Non-stoppable option ignores low-speed stop bit
// - High-speed stop bit is bit 7 of main oscillator control
// - Stable flag bit 7, internal high-speed stop bit 0
// - Main selector bit 2, second select bit 0 of main clock mode
`timescale 1ns/1ps
`include "csc_cfg.svh"
module csc_clock_ctrl #(
  parameter int SETTLE_CYC = `CSC_HS_SETTLE_CYC,
  parameter int CNT_W = 16
) (
  input wire logic clk_in,                             // 200 MHz clock
  input wire logic rst_n_in,                           // Async reset, low
  input wire logic [7:0] main_osc_control_reg_in,      // Oscillator control
  input wire logic [7:0] internal_osc_mode_reg_in,     // Internal osc mode
  input wire logic [7:0] main_clock_mode_reg_in,       // Main clock mode
  input wire logic [7:0] osc_mode_select_reg_in,       // Osc pin mode
  input wire logic [7:0] processor_clock_control_reg_in, // CPU divider
  input wire logic stop_insn_in,                       // STOP executed pulse
  input wire logic wake_in,                            // Stop release pulse
  input wire logic ls_nonstoppable_in,                 // Option: no LS stop
  input wire logic wdt_enable_in,                      // Option: watchdog on
  input wire logic xtal_clk_in,                        // Crystal osc level
  input wire logic ext_clk_in,                         // External clock pin
  input wire logic int_hs_clk_in,                      // Internal HS osc level
  output csc_pkg::csc_osc_en_t osc_en_out,             // Oscillator enables
  output logic [7:0] internal_osc_mode_rd_out,         // Internal osc readback
  output logic [7:0] main_clock_mode_rd_out,           // Main mode readback
  output logic cpu_clock_status_flag_out,              // 1: CPU on HS system
  output logic int_hs_osc_stable_out,                  // HS accuracy settled
  output logic stop_mode_out,                          // In stop mode
  output logic cpu_tick_out,                           // CPU clock tick
  output logic periph_tick_out                         // Peripheral tick
);
  import csc_pkg::*;

  // Field extraction
  wire hs_system_clock_stop =
    main_osc_control_reg_in[`CSC_MOC_HS_STOP_BIT];
  wire int_hs_osc_stop = internal_osc_mode_reg_in[`CSC_RCM_HS_STOP_BIT];
  wire low_speed_osc_stop = internal_osc_mode_reg_in[`CSC_RCM_LS_STOP_BIT];
  wire main_source_select =
    main_clock_mode_reg_in[`CSC_MCM_SRC_SEL_BIT];
  wire main_periph_clock_select =
    main_clock_mode_reg_in[`CSC_MCM_MP_SEL_BIT];
  wire external_clock_select = osc_mode_select_reg_in[`CSC_OSC_EXT_SEL_BIT];
  wire [2:0] cpu_divider =
    processor_clock_control_reg_in[`CSC_PCC_DIV_MSB:`CSC_PCC_DIV_LSB];

  // Pin synchronisers, one private chain per pin
  wire [2:0] pins_w = {int_hs_clk_in, ext_clk_in, xtal_clk_in};
  wire [2:0] rise_w;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      logic sync1_q;
      logic sync2_q;
      logic prev_q;
      always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          sync1_q <= 1'b0;
          sync2_q <= 1'b0;
          prev_q <= 1'b0;
        end else begin
          sync1_q <= pins_w[g];
          sync2_q <= sync1_q;
          prev_q <= sync2_q;
        end
      end
      assign rise_w[g] = sync2_q && !prev_q;
    end
  endgenerate

  // State
  csc_mode_t mode_q;
  csc_mode_t mode_d;
  csc_sel_t sel_q;
  csc_sel_t sel_d;
  logic [2:0] div_req_q;
  logic [2:0] div_req_d;
  logic [CNT_W-1:0] settle_q;
  logic [CNT_W-1:0] settle_d;
  logic stable_q;

  wire in_stop_w = (mode_q == CSC_STOP);
  wire cpu_on_hs_w = sel_q.main_hs;

  // Run controls; the source feeding the CPU ignores its stop bit, but STOP mode halts both
  wire hs_stop_eff_w = hs_system_clock_stop && !cpu_on_hs_w;
  wire int_stop_eff_w = int_hs_osc_stop && cpu_on_hs_w;
  wire hs_run_w = !hs_stop_eff_w && !in_stop_w;
  wire int_run_w = !int_stop_eff_w && !in_stop_w;
  wire ls_run_w = ls_nonstoppable_in || !low_speed_osc_stop;

  // Source ticks; external select picks ext_clk_in or xtal_clk_in for the HS tick and for the oscillator enables
  wire hs_tick_w = hs_run_w &&
    (external_clock_select ? rise_w[1] : rise_w[0]);
  wire int_tick_w = int_run_w && rise_w[2];

  // Requested selection; low-speed clock is never a candidate
  wire req_main_hs_w = main_source_select && main_periph_clock_select;
  wire req_periph_hs_w = main_source_select;
  wire req_src_ok_w = req_main_hs_w ? hs_run_w : int_run_w;
  wire div_legal_w = (cpu_divider <= `CSC_DIV_MAX);

  wire main_tick_w = sel_q.main_hs ? hs_tick_w : int_tick_w;
  wire periph_tick_w = sel_q.periph_hs ? hs_tick_w : int_tick_w;

  logic cpu_div_tick;
  logic cpu_boundary;
  logic periph_div_tick;

  csc_tick_div #(.CODE_W(3), .CNT_W(CNT_W)) u_cpu_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .src_tick_in(main_tick_w),
    .code_in(sel_q.div),
    .tick_out(cpu_div_tick),
    .boundary_out(cpu_boundary)
  );

  csc_tick_div #(.CODE_W(3), .CNT_W(CNT_W)) u_periph_div (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .src_tick_in(periph_tick_w),
    .code_in(3'h0),
    .tick_out(periph_div_tick),
    .boundary_out()
  );

  // Switch only at a CPU period boundary, when the requested CPU source is running
  wire switch_w = cpu_boundary && req_src_ok_w && !in_stop_w;
  assign div_req_d = div_legal_w ? cpu_divider : div_req_q;
  assign sel_d = switch_w ?
    csc_sel_t'{main_hs: req_main_hs_w, periph_hs: req_periph_hs_w,
      div: div_req_q} :
    sel_q;

  // Stop mode: a fresh STOP wins over wake in the same cycle
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      CSC_RUN: if (stop_insn_in) begin
        mode_d = CSC_STOP;
      end
      CSC_STOP: if (wake_in) begin
        mode_d = CSC_RUN;
      end
    endcase
  end

  // Accuracy settle timer on the internal oscillator
  wire settle_done_w = (settle_q >= CNT_W'(SETTLE_CYC));
  assign settle_d = !int_run_w ? '0 :
    (settle_done_w ? settle_q : settle_q + 1'b1);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_q <= CSC_RUN;
      sel_q <= '{main_hs: 1'b0, periph_hs: 1'b0, div: `CSC_DIV_RESET};
      div_req_q <= `CSC_DIV_RESET;
      settle_q <= '0;
      stable_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      sel_q <= sel_d;
      div_req_q <= div_req_d;
      settle_q <= settle_d;
      stable_q <= int_run_w && settle_done_w;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      osc_en_out <= '{xtal: 1'b0, ext_in: 1'b0, int_hs: 1'b1,
        low_speed: 1'b1, wdt: 1'b0};
      internal_osc_mode_rd_out <= 8'h00;
      main_clock_mode_rd_out <= 8'h00;
      cpu_clock_status_flag_out <= 1'b0;
      int_hs_osc_stable_out <= 1'b0;
      stop_mode_out <= 1'b0;
      cpu_tick_out <= 1'b0;
      periph_tick_out <= 1'b0;
    end else begin
      osc_en_out <= '{xtal: hs_run_w && !external_clock_select,
        ext_in: hs_run_w && external_clock_select,
        int_hs: int_run_w,
        low_speed: ls_run_w,
        wdt: ls_run_w && wdt_enable_in};
      internal_osc_mode_rd_out <= {stable_q, 5'h00,
        low_speed_osc_stop, int_hs_osc_stop};
      main_clock_mode_rd_out <= {5'h00, main_source_select,
        sel_q.main_hs, main_periph_clock_select};
      cpu_clock_status_flag_out <= sel_q.main_hs;
      int_hs_osc_stable_out <= stable_q;
      stop_mode_out <= in_stop_w;
      cpu_tick_out <= cpu_div_tick && !in_stop_w;
      periph_tick_out <= periph_div_tick && !in_stop_w;
    end
  end

endmodule

/* hdl/csc_cfg.svh */
// Bit positions, reset values and timing counts of the clock source control
`ifndef CSC_CFG_SVH
`define CSC_CFG_SVH

// Main oscillator control image
`define CSC_MOC_HS_STOP_BIT 7
// Internal oscillator mode image
`define CSC_RCM_STABLE_BIT 7
`define CSC_RCM_LS_STOP_BIT 1
`define CSC_RCM_HS_STOP_BIT 0
// Main clock mode image
`define CSC_MCM_SRC_SEL_BIT 2
`define CSC_MCM_STATUS_BIT 1
`define CSC_MCM_MP_SEL_BIT 0
// Oscillator mode select image
`define CSC_OSC_EXT_SEL_BIT 7
// Processor clock control image
`define CSC_PCC_DIV_MSB 2
`define CSC_PCC_DIV_LSB 0

// Divider codes
`define CSC_DIV_RESET 3'h1
`define CSC_DIV_MAX 3'h4

// Internal oscillator accuracy settle time
`define CSC_CLK_MHZ 200
`define CSC_HS_SETTLE_NS 10000
`define CSC_HS_SETTLE_CYC ((`CSC_HS_SETTLE_NS * `CSC_CLK_MHZ + 999) / 1000)

`endif

/* hdl/csc_pkg.sv */
// Types shared by the clock source control block
package csc_pkg;

  typedef enum logic {
    CSC_RUN,
    CSC_STOP
  } csc_mode_t;

  // Oscillator run controls
  typedef struct packed {
    logic xtal;
    logic ext_in;
    logic int_hs;
    logic low_speed;
    logic wdt;
  } csc_osc_en_t;

  // Applied clock selection
  typedef struct packed {
    logic main_hs;
    logic periph_hs;
    logic [2:0] div;
  } csc_sel_t;

endpackage

/* hdl/csc_tick_div.sv */
// Tick divider producing one output tick per 2^code source ticks
`timescale 1ns/1ps
module csc_tick_div #(
  parameter int CODE_W = 3,
  parameter int CNT_W = 16
) (
  input wire logic clk_in,               // System clock
  input wire logic rst_n_in,             // Async reset, active low
  input wire logic src_tick_in,          // Source clock tick
  input wire logic [CODE_W-1:0] code_in, // Divide by 2^code
  output logic tick_out,                 // Divided tick
  output logic boundary_out              // Period complete, safe to switch
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  wire [CNT_W-1:0] last_w = CNT_W'((1 << code_in) - 1);
  wire wrap_w = src_tick_in && (cnt_q == last_w);

  assign cnt_d = wrap_w ? '0 : (src_tick_in ? cnt_q + 1'b1 : cnt_q);
  assign boundary_out = (cnt_q == '0) && !tick_out;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_q <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_out <= wrap_w;
    end
  end

endmodule

/* verif/csc_clock_ctrl_props.sv */
// Port checks for the clock source control
`timescale 1ns/1ps
module csc_clock_ctrl_props #(
  parameter int SETTLE_CYC = 8
) (
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Reset
  input wire logic [7:0] main_osc_control_reg_in, // Osc control
  input wire logic [7:0] internal_osc_mode_reg_in, // Internal mode
  input wire logic stop_insn_in, // Stop pulse
  input wire logic wake_in, // Wake pulse
  input wire logic ls_nonstoppable_in, // LS lock
  input csc_pkg::csc_osc_en_t osc_en_out, // Enables
  input wire logic cpu_clock_status_flag_out, // Status
  input wire logic int_hs_osc_stable_out, // Stable
  input wire logic stop_mode_out, // Stop mode
  input wire logic cpu_tick_out // CPU tick
);
  import csc_pkg::*;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  logic [7:0] run_q;
  // Cycles of uninterrupted internal oscillator enable
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) run_q <= 8'h00;
    else if (!osc_en_out.int_hs) run_q <= 8'h00;
    else if (run_q != 8'hFF) run_q <= run_q + 8'h01;
  end
  a_stop_entry: assert property (
    stop_insn_in && !stop_mode_out && !wake_in |-> ##[1:2] stop_mode_out)
    else $error("stop not entered");
  a_stop_osc_off: assert property (
    stop_mode_out |-> !osc_en_out.xtal && !osc_en_out.ext_in &&
    !osc_en_out.int_hs) else $error("osc on in stop");
  a_stop_no_tick: assert property (
    stop_mode_out && $past(stop_mode_out) |-> !cpu_tick_out)
    else $error("tick in stop");
  a_hs_feed_kept: assert property (
    cpu_clock_status_flag_out && !stop_mode_out && !$past(stop_mode_out)
    |-> osc_en_out.xtal || osc_en_out.ext_in) else $error("hs lost");
  a_int_feed_kept: assert property (
    !cpu_clock_status_flag_out && !stop_mode_out && !$past(stop_mode_out)
    |-> osc_en_out.int_hs) else $error("int hs lost");
  a_hs_stop_bit: assert property (
    main_osc_control_reg_in[7] && !cpu_clock_status_flag_out
    |=> !osc_en_out.xtal && !osc_en_out.ext_in) else $error("hs not stopped");
  a_ls_locked: assert property (
    ls_nonstoppable_in |=> osc_en_out.low_speed) else $error("ls stopped");
  a_ls_stop_bit: assert property (
    internal_osc_mode_reg_in[1] && !ls_nonstoppable_in
    |=> !osc_en_out.low_speed) else $error("ls on");
  a_stable_drop: assert property (
    !osc_en_out.int_hs |-> ##2 !int_hs_osc_stable_out)
    else $error("stable kept");
  a_stable_settle: assert property (
    $rose(int_hs_osc_stable_out) |-> run_q >= 8'(SETTLE_CYC))
    else $error("stable early");
  cover property (stop_mode_out);
  cover property ($rose(cpu_clock_status_flag_out));
  cover property ($rose(int_hs_osc_stable_out));
endmodule

bind csc_clock_ctrl csc_clock_ctrl_props #(.SETTLE_CYC(SETTLE_CYC)) u_props (
  .clk_in, .rst_n_in, .main_osc_control_reg_in, .internal_osc_mode_reg_in,
  .stop_insn_in, .wake_in, .ls_nonstoppable_in, .osc_en_out,
  .cpu_clock_status_flag_out, .int_hs_osc_stable_out, .stop_mode_out,
  .cpu_tick_out);

/* verif/csc_clock_ctrl_tb.sv */
// Directed bench for the clock source control
`timescale 1ns/1ps
module csc_clock_ctrl_tb;
  import csc_pkg::*;
  logic clk_in = 0, rst_n_in = 0, stp_in = 0, wk_in = 0, ls_ns = 0, wdt = 0;
  logic ihs = 0, xt = 0, sts, stb, stp, ctk, ptk;
  logic [7:0] main_osc_control_reg = 8'h80, internal_osc_mode_reg = 8'h00, main_clock_mode_reg = 8'h00, osm = 8'h00;
  logic [7:0] processor_clock_control_reg = 8'h01, rcm_rd, mcm_rd;
  csc_osc_en_t en;
  int miscompares = 0, checked = 0, n, cnt, pcnt, ph = 0;
  int codes[4] = '{0, 2, 4, 7};
  int rates[4] = '{64, 16, 4, 4};
  always #2.5 clk_in = ~clk_in;
  // Oscillator pins: internal period 4 cycles, crystal 6
  always @(posedge clk_in) begin
    #1 ph++;
    if (ph % 2 == 0) ihs = ~ihs;
    if (ph % 3 == 0) xt = ~xt;
  end
  csc_clock_ctrl #(.SETTLE_CYC(8)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .main_osc_control_reg_in(main_osc_control_reg), .internal_osc_mode_reg_in(internal_osc_mode_reg),
    .main_clock_mode_reg_in(main_clock_mode_reg), .osc_mode_select_reg_in(osm),
    .processor_clock_control_reg_in(processor_clock_control_reg), .stop_insn_in(stp_in),
    .wake_in(wk_in), .ls_nonstoppable_in(ls_ns), .wdt_enable_in(wdt),
    .xtal_clk_in(xt), .ext_clk_in(xt), .int_hs_clk_in(ihs), .osc_en_out(en),
    .internal_osc_mode_rd_out(rcm_rd), .main_clock_mode_rd_out(mcm_rd),
    .cpu_clock_status_flag_out(sts), .int_hs_osc_stable_out(stb),
    .stop_mode_out(stp), .cpu_tick_out(ctk), .periph_tick_out(ptk));
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask
  task automatic ticks(int k);
    cnt = 0;
    pcnt = 0;
    repeat (k) begin
      cyc(1);
      cnt += ctk;
      pcnt += ptk;
    end
  endtask
  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    miscompares++;
    final_report();
  end
  initial begin
    cyc(8);
    rst_n_in = 1;
    cyc(1);
    chk("osc_en", 8'h06, 8'(en));
    chk("status", 8'h00, 8'(sts));
    for (n = 0; n < 50 && stb !== 1'b1; n++) cyc(1);
    chk("rcm_rd", 8'h80, rcm_rd);
    for (int i = 0; i < 4; i++) begin
      processor_clock_control_reg = 8'(codes[i]);
      cyc(80);
      ticks(256);
      chk("cpu_ticks", 8'(rates[i]), (cnt - rates[i]) inside {[-1:1]} ?
        8'(rates[i]) : 8'(cnt));
      chk("periph_ticks", 8'h40, 8'(pcnt));
    end
    processor_clock_control_reg = 8'h01;
    internal_osc_mode_reg = 8'h01;
    cyc(3);
    chk("int_hs_held", 8'h01, 8'(en.int_hs));
    internal_osc_mode_reg = 8'h00;
    osm = 8'h80;
    main_osc_control_reg = 8'h00;
    cyc(2);
    chk("hs_ext", 8'h08, 8'(en) & 8'h18);
    osm = 8'h00;
    cyc(2);
    chk("hs_xtal", 8'h10, 8'(en) & 8'h18);
    main_clock_mode_reg = 8'h05;
    for (n = 0; n < 200 && sts !== 1'b1; n++) cyc(1);
    cyc(1);
    chk("mcm_rd", 8'h07, mcm_rd);
    main_osc_control_reg = 8'h80;
    cyc(3);
    chk("hs_held", 8'h10, 8'(en) & 8'h18);
    main_osc_control_reg = 8'h00;
    internal_osc_mode_reg = 8'h01;
    cyc(4);
    chk("int_hs_off", 8'h01, 8'({en.int_hs, stb, rcm_rd[0]}));
    internal_osc_mode_reg = 8'h00;
    cyc(2);
    chk("int_hs_on", 8'h01, 8'(en.int_hs));
    main_clock_mode_reg = 8'h00;
    for (n = 0; n < 200 && sts !== 1'b0; n++) cyc(1);
    chk("status", 8'h00, 8'(sts));
    main_osc_control_reg = 8'h80;
    cyc(2);
    chk("hs_stop", 8'h00, 8'(en) & 8'h18);
    internal_osc_mode_reg = 8'h02;
    cyc(2);
    chk("ls_stop", 8'h00, 8'(en.low_speed));
    ls_ns = 1;
    cyc(2);
    chk("ls_locked", 8'h01, 8'(en.low_speed));
    ls_ns = 0;
    internal_osc_mode_reg = 8'h00;
    wdt = 1;
    main_osc_control_reg = 8'h00;
    cyc(2);
    chk("ls_wdt", 8'h03, 8'(en) & 8'h03);
    stp_in = 1;
    cyc(1);
    stp_in = 0;
    cyc(2);
    chk("stop_en", 8'h23, 8'({stp, en}));
    ticks(20);
    chk("stop_ticks", 8'h00, 8'(cnt));
    chk("stop_pticks", 8'h00, 8'(pcnt));
    wk_in = 1;
    cyc(1);
    wk_in = 0;
    cyc(3);
    chk("wake_en", 8'h17, 8'({stp, en}));
    final_report();
  end
endmodule
